//--- hw/csp_pkg.sv
// constants and types shared by the codec serial port design
package csp_pkg;

    // *****************************
    // word format
    // *****************************
    localparam int           WORD_W     = 16;
    localparam int           CNT_W      = 4;
    localparam logic [3:0]   MSB_IDX    = 4'hF;
    localparam int           CTRL_FLAG  = 15;   // set in mixed mode for a control word
    localparam int           ADDR_LSB   = 8;    // control register address field
    localparam int           ADDR_MSB   = 10;
    localparam logic [2:0]   REG_A_ADDR = 3'h0; // mode-selecting register
    localparam int           MODE_LSB   = 0;
    localparam int           MODE_MSB   = 1;

    // *****************************
    // serial clock timing
    // *****************************
    localparam int           CLK_PERIOD_NS  = 4;
    localparam int           SCLK_PERIOD_NS = 128;
    localparam int           SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int           DIV_W          = 5;
    localparam logic [4:0]   DIV_LAST       = 5'(SCLK_HALF_CYC - 1);

    // *****************************
    // modes and states
    // *****************************
    typedef enum logic [1:0]
    {
        CSP_MODE_PROGRAM = 2'h0,
        CSP_MODE_DATA    = 2'h1,
        CSP_MODE_MIXED   = 2'h3
    } csp_mode_t;

    localparam logic [1:0]   MODE_RESET = 2'h0;

    typedef enum logic [1:0]
    {
        CSP_RX_IDLE  = 2'b01,
        CSP_RX_SHIFT = 2'b10
    } csp_rx_state_t;

    typedef enum logic [2:0]
    {
        CSP_TX_IDLE  = 3'b001,
        CSP_TX_SYNC  = 3'b010,
        CSP_TX_SHIFT = 3'b100
    } csp_tx_state_t;

endpackage

//--- hw/csp_rx_if.sv
// received-word carrier between the deserialiser and the port core
`timescale 1ns/1ns
interface csp_rx_if;
    logic [15:0] word;
    logic        valid;

    modport rx
    (
        output word,
        output valid
    );

    modport core
    (
        input  word,
        input  valid
    );
endinterface

//--- hw/csp_rx.sv
// serial input deserialiser: one frame sync cycle, then 16 bits msb first
`timescale 1ns/1ns
module csp_rx
    import csp_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_fall,
    input  wire logic i_sync,
    input  wire logic i_data,
    csp_rx_if.rx      rx
);

    csp_rx_state_t      state_ff;
    logic [CNT_W-1:0]   cnt_ff;
    logic [WORD_W-1:0]  sr_ff;
    logic [WORD_W-1:0]  word_ff;
    logic               valid_ff;

    // a high sync at a falling edge opens a word
    wire start_word = i_fall && i_sync && (state_ff == CSP_RX_IDLE);
    wire last_bit   = i_fall && (state_ff == CSP_RX_SHIFT) && (cnt_ff == 4'h0);

    assign rx.word  = word_ff;
    assign rx.valid = valid_ff;

    // *****************************
    // shift state machine
    // *****************************
    // syncs seen mid-word are ignored; every word needs its own sync
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_ff <= CSP_RX_IDLE;
            cnt_ff   <= 4'h0;
            sr_ff    <= 16'h0000;
        end
        else if (i_fall)
        begin
            unique case (state_ff)
                CSP_RX_IDLE:
                begin
                    // R3 sync precedes msb
                    if (start_word)
                    begin
                        state_ff <= CSP_RX_SHIFT;
                        cnt_ff   <= MSB_IDX;
                    end
                end
                CSP_RX_SHIFT:
                begin
                    // R15 msb first shift
                    sr_ff  <= {sr_ff[WORD_W-2:0], i_data};
                    cnt_ff <= cnt_ff - 4'h1;
                    if (cnt_ff == 4'h0)
                    begin
                        state_ff <= CSP_RX_IDLE;
                    end
                end
                default:
                begin
                    state_ff <= CSP_RX_IDLE;
                end
            endcase
        end
    end

    // R1 sixteen-bit word out
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            word_ff  <= 16'h0000;
            valid_ff <= 1'b0;
        end
        else
        begin
            valid_ff <= last_bit;
            if (last_bit)
            begin
                word_ff <= {sr_ff[WORD_W-2:0], i_data};
            end
        end
    end

endmodule

//--- hw/csp_port.sv
// codec serial port: serial clock, framed output words, input decode, mode
// *****************************
// How it works
// R1 - every word is exactly sixteen bits in both directions
// R2 - each word, either direction, has its own frame sync pulse
// R3 - frame sync is high in the clock cycle before the msb
// R4 - frame syncs are active high
// R5 - host shifts with the serial clock this port drives
// R6 - output frame sync is driven here and only sampled by host
// R7 - host tx sync is our sync in loop-back, host-driven otherwise
// R8 - two sample words go to the host each sample period
// R9 - mixed non-loop-back: host may add control words per period
// R10 - host should send control words before the update word
// R11 - mixed mode period without update word repeats previous output sample
// R12 - words are exchanged after reset, in data mode and mixed mode
// R13 - loop-back wires output sync to both host syncs and our input sync
// R14 - a write to the first control register selects the mode
// R15 - words shift msb first, one bit per clock, after the sync
// *****************************
`timescale 1ns/1ns
module csp_port
    import csp_pkg::*;
(
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RESET,
    input  wire logic        I_SAMPLE_TICK,
    input  wire logic [15:0] I_ADC_WORD,
    input  wire logic [15:0] I_AUX_WORD,
    input  wire logic        I_SERIAL_IN_LINE,
    input  wire logic        I_IN_FRAME_SYNC,
    output logic             O_SCLK,
    output logic             O_SERIAL_OUT_LINE,
    output logic             O_OUT_FRAME_SYNC,
    output logic [1:0]       O_MODE,
    output logic [15:0]      O_DAC_WORD,
    output logic             O_DAC_VALID,
    output logic [15:0]      O_CTRL_WORD,
    output logic             O_CTRL_VALID
);

    // *****************************
    // serial clock divider
    // *****************************
    logic [DIV_W-1:0] div_ff;
    logic             sclk_ff;

    wire div_wrap = (div_ff == DIV_LAST);
    wire sclk_rise = div_wrap && !sclk_ff;
    wire sclk_fall = div_wrap && sclk_ff;

    // R5 port owns the bit clock
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            div_ff  <= 5'h00;
            sclk_ff <= 1'b0;
        end
        else
        begin
            div_ff  <= div_wrap ? 5'h00 : div_ff + 5'h01;
            sclk_ff <= div_wrap ? !sclk_ff : sclk_ff;
        end
    end

    // *****************************
    // pin synchronisers
    // *****************************
    logic sdi_s1_ff;
    logic sdi_s2_ff;
    logic fs_s1_ff;
    logic fs_s2_ff;

    // R13 in sync may be our own out sync looped back
    // pins change on our rising edge, settle long before the fall sample
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            sdi_s1_ff <= 1'b0;
            sdi_s2_ff <= 1'b0;
            fs_s1_ff  <= 1'b0;
            fs_s2_ff  <= 1'b0;
        end
        else
        begin
            sdi_s1_ff <= I_SERIAL_IN_LINE;
            sdi_s2_ff <= sdi_s1_ff;
            fs_s1_ff  <= I_IN_FRAME_SYNC;
            fs_s2_ff  <= fs_s1_ff;
        end
    end

    // *****************************
    // input deserialiser
    // *****************************
    csp_rx_if rx_bus ();

    // R4 high level marks the sync
    csp_rx u_rx
    (
        .i_clk   (I_REF_CLK),
        .i_reset (I_RESET),
        .i_fall  (sclk_fall),
        .i_sync  (fs_s2_ff),
        .i_data  (sdi_s2_ff),
        .rx      (rx_bus.rx)
    );

    // *****************************
    // word decode and mode
    // *****************************
    logic [1:0]  mode_ff;
    logic [15:0] dac_ff;
    logic        dac_valid_ff;
    logic        dac_seen_ff;
    logic [15:0] ctrl_ff;
    logic        ctrl_valid_ff;

    // R9 mixed mode flags control words by the top bit
    wire is_mixed  = (mode_ff == CSP_MODE_MIXED);
    wire is_ctrl   = (mode_ff == CSP_MODE_PROGRAM) || (is_mixed && rx_bus.word[CTRL_FLAG]);
    wire ctrl_hit  = rx_bus.valid && is_ctrl;
    wire dac_hit   = rx_bus.valid && !is_ctrl;
    wire reg_a_hit = ctrl_hit && (rx_bus.word[ADDR_MSB:ADDR_LSB] == REG_A_ADDR);
    wire [1:0] mode_req = rx_bus.word[MODE_MSB:MODE_LSB];
    // unused code falls back to program mode so words keep being taken
    wire [1:0] nxt_mode = (mode_req == 2'h2) ? MODE_RESET : mode_req;
    // R11 no update word this period, repeat the last one
    wire repeat_dac = I_SAMPLE_TICK && is_mixed && !dac_seen_ff && !dac_hit;

    // R14 first register picks mode
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            mode_ff <= MODE_RESET;
        end
        else if (reg_a_hit)
        begin
            mode_ff <= nxt_mode;
        end
    end

    // control words are handed on with a one-cycle strobe
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            ctrl_ff       <= 16'h0000;
            ctrl_valid_ff <= 1'b0;
        end
        else
        begin
            ctrl_valid_ff <= ctrl_hit;
            ctrl_ff       <= ctrl_hit ? rx_bus.word : ctrl_ff;
        end
    end

    // R11 held sample is strobed again
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            dac_ff       <= 16'h0000;
            dac_valid_ff <= 1'b0;
            dac_seen_ff  <= 1'b0;
        end
        else
        begin
            dac_ff       <= dac_hit ? rx_bus.word : dac_ff;
            dac_valid_ff <= dac_hit || repeat_dac;
            // an arriving word wins over the period clear
            dac_seen_ff  <= dac_hit || (dac_seen_ff && !I_SAMPLE_TICK);
        end
    end

    // *****************************
    // output serialiser
    // *****************************
    csp_tx_state_t tx_state_ff;
    logic [15:0]   hold0_ff;
    logic [15:0]   hold1_ff;
    logic          pend_ff;
    logic [15:0]   sr_ff;
    logic [15:0]   next_ff;
    logic          second_ff;
    logic [3:0]    cnt_ff;
    logic          sdo_ff;
    logic          fs_ff;

    wire tx_start = sclk_rise && (tx_state_ff == CSP_TX_IDLE) && pend_ff;
    wire word_end = sclk_rise && (tx_state_ff == CSP_TX_SHIFT) && (cnt_ff == 4'h0);

    // R8 two words latched per period
    // R12 sent in every mode
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            hold0_ff <= 16'h0000;
            hold1_ff <= 16'h0000;
            pend_ff  <= 1'b0;
        end
        else
        begin
            hold0_ff <= I_SAMPLE_TICK ? I_ADC_WORD : hold0_ff;
            hold1_ff <= I_SAMPLE_TICK ? I_AUX_WORD : hold1_ff;
            pend_ff  <= I_SAMPLE_TICK || (pend_ff && !tx_start);
        end
    end

    // state moves and outputs change only on rising serial clock
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            tx_state_ff <= CSP_TX_IDLE;
            sr_ff       <= 16'h0000;
            next_ff     <= 16'h0000;
            second_ff   <= 1'b0;
            cnt_ff      <= 4'h0;
            sdo_ff      <= 1'b0;
            fs_ff       <= 1'b0;
        end
        else if (sclk_rise)
        begin
            unique case (tx_state_ff)
                CSP_TX_IDLE:
                begin
                    // R6 device drives output sync
                    if (pend_ff)
                    begin
                        tx_state_ff <= CSP_TX_SYNC;
                        sr_ff       <= hold0_ff;
                        next_ff     <= hold1_ff;
                        second_ff   <= 1'b0;
                        fs_ff       <= 1'b1;
                    end
                end
                CSP_TX_SYNC:
                begin
                    // R3 msb follows sync
                    tx_state_ff <= CSP_TX_SHIFT;
                    fs_ff       <= 1'b0;
                    sdo_ff      <= sr_ff[MSB_IDX];
                    cnt_ff      <= MSB_IDX;
                end
                CSP_TX_SHIFT:
                begin
                    // R15 msb first, one per clock
                    if (!word_end)
                    begin
                        sdo_ff <= sr_ff[cnt_ff - 4'h1];
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                    // R2 second word gets own sync
                    else if (!second_ff)
                    begin
                        tx_state_ff <= CSP_TX_SYNC;
                        sr_ff       <= next_ff;
                        second_ff   <= 1'b1;
                        fs_ff       <= 1'b1;
                        sdo_ff      <= 1'b0;
                    end
                    else
                    begin
                        tx_state_ff <= CSP_TX_IDLE;
                        sdo_ff      <= 1'b0;
                    end
                end
                default:
                begin
                    tx_state_ff <= CSP_TX_IDLE;
                end
            endcase
        end
    end

    // *****************************
    // outputs
    // *****************************
    assign O_SCLK            = sclk_ff;
    assign O_SERIAL_OUT_LINE = sdo_ff;
    assign O_OUT_FRAME_SYNC  = fs_ff;
    assign O_MODE            = mode_ff;
    assign O_DAC_WORD        = dac_ff;
    assign O_DAC_VALID       = dac_valid_ff;
    assign O_CTRL_WORD       = ctrl_ff;
    assign O_CTRL_VALID      = ctrl_valid_ff;

endmodule

//--- tb/csp_port_asserts.sv
// assertion checker for the codec serial port top level
`timescale 1ns/1ns
module csp_port_asserts
(
    input wire logic        I_REF_CLK,
    input wire logic        I_RESET,
    input wire logic        O_SCLK,
    input wire logic        O_SERIAL_OUT_LINE,
    input wire logic        O_OUT_FRAME_SYNC,
    input wire logic [1:0]  O_MODE,
    input wire logic [15:0] O_DAC_WORD,
    input wire logic        O_DAC_VALID,
    input wire logic [15:0] O_CTRL_WORD,
    input wire logic        O_CTRL_VALID
);
    logic [15:0] low_cnt_ff;

    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);

    // cycles with output sync low; starts saturated so the first sync passes
    always_ff @(posedge I_REF_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            low_cnt_ff <= 16'hFFFF;
        else if (O_OUT_FRAME_SYNC)
            low_cnt_ff <= 16'h0000;
        else if (low_cnt_ff != 16'hFFFF)
            low_cnt_ff <= low_cnt_ff + 16'h0001;
    end

    // ****************************
    // link and word checks
    // ****************************
    a_sync_on_rise: assert property ($changed(O_OUT_FRAME_SYNC) |-> $rose(O_SCLK))
        else $error("sync moved off a clock rise");
    a_data_on_rise: assert property ($changed(O_SERIAL_OUT_LINE) |-> $rose(O_SCLK))
        else $error("data moved off a clock rise");
    a_sclk_high: assert property ($rose(O_SCLK) |-> ##16 $fell(O_SCLK))
        else $error("serial clock high phase wrong");
    a_sclk_low: assert property ($fell(O_SCLK) |-> ##16 $rose(O_SCLK))
        else $error("serial clock low phase wrong");
    a_sync_width: assert property ($rose(O_OUT_FRAME_SYNC) |->
        O_OUT_FRAME_SYNC[*8] ##25 $fell(O_OUT_FRAME_SYNC))
        else $error("sync not one clock period");
    a_word_length: assert property ($rose(O_OUT_FRAME_SYNC) |-> low_cnt_ff >= 16'h0200)
        else $error("sync came before sixteen bits");
    a_mode_cause: assert property ($changed(O_MODE) |->
        O_CTRL_VALID && O_CTRL_WORD[10:8] == 3'h0)
        else $error("mode changed without a mode write");
    a_mode_legal: assert property (O_MODE != 2'h2)
        else $error("illegal mode code");
    a_dac_pulse: assert property (O_DAC_VALID |=> !O_DAC_VALID[*8])
        else $error("converter words too close");
    a_dac_hold: assert property ($changed(O_DAC_WORD) |-> O_DAC_VALID)
        else $error("converter word changed alone");
    a_ctrl_hold: assert property ($changed(O_CTRL_WORD) |-> O_CTRL_VALID)
        else $error("control word changed alone");

    c_sync: cover property ($rose(O_OUT_FRAME_SYNC));
    c_mixed_ctrl: cover property (O_CTRL_VALID && O_MODE == 2'h3);
    c_repeat: cover property (O_DAC_VALID && $stable(O_DAC_WORD));
endmodule

bind csp_port csp_port_asserts u_chk
(
    .I_REF_CLK         (I_REF_CLK),
    .I_RESET           (I_RESET),
    .O_SCLK            (O_SCLK),
    .O_SERIAL_OUT_LINE (O_SERIAL_OUT_LINE),
    .O_OUT_FRAME_SYNC  (O_OUT_FRAME_SYNC),
    .O_MODE            (O_MODE),
    .O_DAC_WORD        (O_DAC_WORD),
    .O_DAC_VALID       (O_DAC_VALID),
    .O_CTRL_WORD       (O_CTRL_WORD),
    .O_CTRL_VALID      (O_CTRL_VALID)
);

//--- tb/csp_host_model.sv
// behavioural host serial port facing the codec port
`timescale 1ns/1ns
module csp_host_model
(
    input  wire logic   sclk,
    input  wire logic   serial_out_line,
    input  wire logic   fs_out,
    input  wire logic   lb,
    output logic        serial_in_line,
    output logic        fs_in,
    output logic [15:0] rx_word,
    output int          rx_cnt
);
    logic [15:0] tx_q[$];
    logic [15:0] sh;
    int          nb   = -1;
    int          rb   = -1;
    int          gap  = 0;
    int          idle = 0;

    initial
    begin
        serial_in_line     = 1'b0;
        fs_in   = 1'b0;
        rx_word = 16'h0000;
        rx_cnt  = 0;
    end

    // non-loop-back: own sync per word, msb first, device clock
    always @(posedge sclk)
    begin
        fs_in = 1'b0;
        if (nb >= 0)
        begin
            serial_in_line = sh[nb];
            nb  = nb - 1;
        end
        else
        begin
            serial_in_line = ~serial_in_line; // released line toggles so stale bits never pass
            if (idle > 0)
                idle = idle - 1;
            else if (!lb && tx_q.size() > 0)
            begin
                sh    = tx_q.pop_front();
                fs_in = 1'b1;
                nb    = 15;
                idle  = gap;
            end
        end
    end

    // samples device sync and data on the falling edge
    // loop-back: the device's out sync also frames our next word
    always @(negedge sclk)
    begin
        if (lb && fs_out && nb < 0 && tx_q.size() > 0)
        begin
            sh = tx_q.pop_front();
            nb = 15;
        end
        if (rb >= 0)
        begin
            rx_word[rb] = serial_out_line;
            rb = rb - 1;
            if (rb < 0)
                rx_cnt = rx_cnt + 1;
        end
        else if (fs_out)
            rb = 15;
    end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the codec serial port
`timescale 1ns/1ns
module tb_top;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        tick = 1'b0;
    logic        lb   = 1'b0;
    logic [15:0] adc  = 16'h0000;
    logic [15:0] aux  = 16'h0000;
    logic        serial_in_line, fsi, sclk, serial_out_line, fso, dv, cv;
    logic [1:0]  mode;
    logic [15:0] dac, ctl, w1;
    logic [15:0] exp_rx[$];
    logic [15:0] exp_dac[$];
    logic [17:0] exp_ctl[$];
    int          errors  = 0;
    int          checked = 0;
    int          seed    = 32'h7f6a;

    initial
    begin
        forever #2 clk = ~clk;
    end

    csp_port uut
    (
        .I_REF_CLK         (clk),
        .I_RESET           (rst),
        .I_SAMPLE_TICK     (tick),
        .I_ADC_WORD        (adc),
        .I_AUX_WORD        (aux),
        .I_SERIAL_IN_LINE  (serial_in_line),
        .I_IN_FRAME_SYNC   (lb ? fso : fsi), // loop-back wiring
        .O_SCLK            (sclk),
        .O_SERIAL_OUT_LINE (serial_out_line),
        .O_OUT_FRAME_SYNC  (fso),
        .O_MODE            (mode),
        .O_DAC_WORD        (dac),
        .O_DAC_VALID       (dv),
        .O_CTRL_WORD       (ctl),
        .O_CTRL_VALID      (cv)
    );

    csp_host_model h
    (
        .sclk    (sclk),
        .serial_out_line     (serial_out_line),
        .fs_out  (fso),
        .lb      (lb),
        .serial_in_line     (serial_in_line),
        .fs_in   (fsi),
        .rx_word (),
        .rx_cnt  ()
    );

    // ****************************
    // shared tasks
    // ****************************
    task check(input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // queue one host word and note what should come out
    task hsend(input logic [15:0] w, input bit c, input logic [1:0] m);
        if (c)
            exp_ctl.push_back({m, w});
        else
            exp_dac.push_back(w);
        h.tx_q.push_back(w);
    endtask

    task wait_idle;
        for (int i = 0; i < 20000 && (h.tx_q.size() > 0 || h.nb >= 0); i++)
            @(posedge clk);
        repeat (64) @(posedge clk);
    endtask

    // one sample period: two words to the host
    task stick;
        int c;
        c = h.rx_cnt;
        @(posedge clk) #1;
        adc  = $random(seed);
        aux  = $random(seed);
        tick = 1'b1;
        exp_rx.push_back(adc);
        exp_rx.push_back(aux);
        @(posedge clk) #1;
        tick = 1'b0;
        for (int i = 0; i < 3000 && h.rx_cnt < c + 2; i++)
            @(posedge clk);
    endtask

    task summarize;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // result watchers: oldest note against each result
    always @(posedge clk)
    begin
        if (dv === 1'b1)
            check({2'h0, dac}, exp_dac.size() ? {2'h0, exp_dac.pop_front()} : 'x);
        if (cv === 1'b1)
            check({mode, ctl}, exp_ctl.size() ? exp_ctl.pop_front() : 'x);
    end

    always @(h.rx_cnt)
        check({2'h0, h.rx_word}, exp_rx.size() ? {2'h0, exp_rx.pop_front()} : 'x);

    initial
    begin
        #160000;
        errors++;
        summarize();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        check({mode, sclk, fso, serial_out_line, dv, cv}, 7'h00);
        stick();
        // other register, then mode write into mixed, back to back
        hsend(16'h0205, 1'b1, 2'h0);
        hsend(16'h0003, 1'b1, 2'h3);
        wait_idle();
        // control before the update word, then a period without one
        h.gap = 2;
        w1 = $random(seed) & 16'h7FFF;
        hsend(16'h8205, 1'b1, 2'h3);
        hsend(w1, 1'b0, 2'h3);
        wait_idle();
        stick();
        exp_dac.push_back(w1);
        stick();
        hsend(16'h8002, 1'b1, 2'h0);
        hsend(16'h0001, 1'b1, 2'h1);
        wait_idle();
        // data mode: every word is a converter word
        for (int i = 0; i < 6; i++)
        begin
            h.gap = {$random(seed)} % 3;
            hsend($random(seed), 1'b0, 2'h1);
        end
        wait_idle();
        // loop-back: the device's own out sync frames the host's words
        #1 lb = 1'b1;
        hsend($random(seed), 1'b0, 2'h1);
        hsend($random(seed), 1'b0, 2'h1);
        stick();
        #1 lb = 1'b0;
        stick();
        stick();
        check(exp_rx.size() + exp_dac.size() + exp_ctl.size(), 18'h0);
        summarize();
    end
endmodule
